// *** src/mmpc_top.sv ***
// Four-channel pulse counter with shared mode, alarms and register port.
`include "mmpc_defines.svh"

module mmpc_top #(
    parameter int CH_N  = 4,
    parameter int CNT_W = 32
) (
    input  wire logic                     ref_clk,
    input  wire logic                     nrst,
    input  wire logic [`MMPC_ADDR_W-1:0]  addr,
    input  wire logic [31:0]              wdata,
    input  wire logic                     wr,
    input  wire logic                     rd,
    output logic      [31:0]              rdata,
    input  wire logic [CH_N-1:0]          up_pulse_pos,
    input  wire logic [CH_N-1:0]          direction_in_pos,
    input  wire logic [CH_N-1:0]          direction_open,
    output logic [CH_N-1:0]               high_alarm,
    output logic [CH_N-1:0]               low_alarm,
    output logic                          irq
);

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    logic [1:0]           mode_q;
    logic                 iso_q;
    logic                 latch_q;
    logic                 clr_q;
    logic [3*CH_N-1:0]    int_stat_q;
    logic [3*CH_N-1:0]    int_mask_q;
    logic [31:0]          rdata_q;
    logic                 irq_q;
    logic                 ctrl_wr;
    logic                 mode_chg;
    logic                 ch_sel;
    logic [1:0]           ch_idx;
    logic [2:0]           fld;

    assign ctrl_wr  = wr && (addr == `MMPC_OFF_CTRL);
    // A write that keeps the same mode must not wipe the counts.
    assign mode_chg = ctrl_wr && (wdata[`MMPC_CTRL_MODE_MSB:`MMPC_CTRL_MODE_LSB] != mode_q);
    assign ch_sel   = addr[`MMPC_CH_REGION];
    assign ch_idx   = addr[`MMPC_CH_MSB:`MMPC_CH_LSB];
    assign fld      = addr[`MMPC_FLD_MSB:`MMPC_FLD_LSB];

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            mode_q  <= mmpc_pkg::MODE_UPDOWN;
            iso_q   <= 1'b0;
            latch_q <= 1'b0;
        end
        else if (ctrl_wr)
        begin
            mode_q  <= wdata[`MMPC_CTRL_MODE_MSB:`MMPC_CTRL_MODE_LSB];
            iso_q   <= wdata[`MMPC_CTRL_ISO];
            latch_q <= wdata[`MMPC_CTRL_LATCH];
        end
    end

    // The clear bit stands for one cycle, does its work, then reads back zero.
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            clr_q <= 1'b0;
        else
            clr_q <= ctrl_wr && wdata[`MMPC_CTRL_CLR];
    end

    // ----------------------------------------------------------------
    // Input synchronisers and edge detect
    // ----------------------------------------------------------------
    logic [CH_N-1:0] up_s1_q;
    logic [CH_N-1:0] up_s2_q;
    logic [CH_N-1:0] up_s3_q;
    logic [CH_N-1:0] dn_s1_q;
    logic [CH_N-1:0] dn_s2_q;
    logic [CH_N-1:0] dn_s3_q;
    logic [CH_N-1:0] op_s1_q;
    logic [CH_N-1:0] op_s2_q;

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            up_s1_q <= '0;
            up_s2_q <= '0;
            up_s3_q <= '0;
            dn_s1_q <= '0;
            dn_s2_q <= '0;
            dn_s3_q <= '0;
            op_s1_q <= '0;
            op_s2_q <= '0;
        end
        else
        begin
            up_s1_q <= up_pulse_pos;
            up_s2_q <= up_s1_q;
            up_s3_q <= up_s2_q;
            dn_s1_q <= direction_in_pos;
            dn_s2_q <= dn_s1_q;
            dn_s3_q <= dn_s2_q;
            op_s1_q <= direction_open;
            op_s2_q <= op_s1_q;
        end
    end

    // ----------------------------------------------------------------
    // Count direction per channel
    // ----------------------------------------------------------------
    logic [CH_N-1:0] up_edge;
    logic [CH_N-1:0] dn_edge;
    logic [CH_N-1:0] dir_lvl;
    logic [CH_N-1:0] inc;
    logic [CH_N-1:0] dec;

    assign up_edge = up_s2_q & ~up_s3_q;
    assign dn_edge = dn_s2_q & ~dn_s3_q;

    always_comb
    begin
        for (int i = 0; i < CH_N; i++)
        begin
            // An open TTL input floats high, an open isolated input reads low.
            dir_lvl[i] = op_s2_q[i] ? ~iso_q : dn_s2_q[i];
            case (mmpc_pkg::mode_type'(mode_q))
                mmpc_pkg::MODE_UPDOWN:
                begin
                    inc[i] = up_edge[i] & ~dn_edge[i];
                    dec[i] = dn_edge[i] & ~up_edge[i];
                end
                mmpc_pkg::MODE_BIDIR:
                begin
                    inc[i] = up_edge[i] & dir_lvl[i];
                    dec[i] = up_edge[i] & ~dir_lvl[i];
                end
                mmpc_pkg::MODE_FREQ:
                begin
                    inc[i] = up_edge[i];
                    dec[i] = 1'b0;
                end
                default:
                begin
                    inc[i] = 1'b0;
                    dec[i] = 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Counters, limits and overflow tallies
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] cnt_q   [CH_N];
    logic [CNT_W-1:0] init_q  [CH_N];
    logic [CNT_W-1:0] high_q  [CH_N];
    logic [CNT_W-1:0] low_q   [CH_N];
    logic [31:0]      tally_q [CH_N];
    logic [CH_N-1:0]  wrap;

    always_comb
    begin
        for (int i = 0; i < CH_N; i++)
            wrap[i] = (inc[i] && cnt_q[i] == `MMPC_CNT_MAX) || (dec[i] && cnt_q[i] == `MMPC_CNT_MIN);
    end

    always_ff @(posedge ref_clk)
    begin
        for (int i = 0; i < CH_N; i++)
        begin
            if (!nrst || mode_chg)
            begin
                cnt_q[i]   <= `MMPC_CNT_MIN;
                tally_q[i] <= '0;
            end
            else if (wr && ch_sel && ch_idx == 2'(i) && fld == `MMPC_FLD_COUNT)
                cnt_q[i] <= wdata;
            else if (wrap[i])
            begin
                cnt_q[i] <= init_q[i];
                if (inc[i])
                    tally_q[i] <= tally_q[i] + 32'h00000001;
                else
                    tally_q[i] <= tally_q[i] - 32'h00000001;
            end
            else if (inc[i])
                cnt_q[i] <= cnt_q[i] + 32'h00000001;
            else if (dec[i])
                cnt_q[i] <= cnt_q[i] - 32'h00000001;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        for (int i = 0; i < CH_N; i++)
        begin
            if (!nrst)
            begin
                init_q[i] <= `MMPC_CNT_MIN;
                high_q[i] <= `MMPC_HIGH_RST;
                low_q[i]  <= `MMPC_LOW_RST;
            end
            else if (wr && ch_sel && ch_idx == 2'(i))
            begin
                if (fld == `MMPC_FLD_INIT)
                    init_q[i] <= wdata;
                if (fld == `MMPC_FLD_HIGH)
                    high_q[i] <= wdata;
                if (fld == `MMPC_FLD_LOW)
                    low_q[i] <= wdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // Alarms
    // ----------------------------------------------------------------
    logic [CH_N-1:0] hi_hit;
    logic [CH_N-1:0] lo_hit;
    logic [CH_N-1:0] hi_q;
    logic [CH_N-1:0] lo_q;

    always_comb
    begin
        for (int i = 0; i < CH_N; i++)
        begin
            hi_hit[i] = cnt_q[i] > high_q[i];
            lo_hit[i] = cnt_q[i] < low_q[i];
        end
    end

    // A still-present hit re-asserts the alarm even in the clearing cycle.
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            hi_q <= '0;
            lo_q <= '0;
        end
        else
        begin
            hi_q <= hi_hit | (hi_q & {CH_N{latch_q & ~clr_q}});
            lo_q <= lo_hit;
        end
    end

    assign high_alarm = hi_q;
    assign low_alarm  = lo_q;

    // ----------------------------------------------------------------
    // Interrupt status and mask
    // ----------------------------------------------------------------
    logic [3*CH_N-1:0] int_evt;

    assign int_evt = {wrap, lo_hit & ~lo_q, hi_hit & ~hi_q};

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            int_mask_q <= '0;
        else if (wr && addr == `MMPC_OFF_INT_MASK)
            int_mask_q <= wdata[3*CH_N-1:0];
    end

    // New events win over a write-one-to-clear in the same cycle.
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            int_stat_q <= '0;
        else if (wr && addr == `MMPC_OFF_INT_STAT)
            int_stat_q <= (int_stat_q & ~wdata[3*CH_N-1:0]) | int_evt;
        else
            int_stat_q <= int_stat_q | int_evt;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            irq_q <= 1'b0;
        else
            irq_q <= |(int_stat_q & int_mask_q);
    end

    assign irq = irq_q;

    // ----------------------------------------------------------------
    // Register read port
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!nrst || !rd)
            rdata_q <= '0;
        else if (ch_sel)
        begin
            case (fld)
                `MMPC_FLD_COUNT: rdata_q <= cnt_q[ch_idx];
                `MMPC_FLD_INIT:  rdata_q <= init_q[ch_idx];
                `MMPC_FLD_HIGH:  rdata_q <= high_q[ch_idx];
                `MMPC_FLD_LOW:   rdata_q <= low_q[ch_idx];
                `MMPC_FLD_TALLY: rdata_q <= tally_q[ch_idx];
                `MMPC_FLD_ALARM: rdata_q <= {30'h0, lo_q[ch_idx], hi_q[ch_idx]};
                default:         rdata_q <= '0;
            endcase
        end
        else
        begin
            case (addr)
                `MMPC_OFF_CTRL:     rdata_q <= {27'h0, clr_q, latch_q, iso_q, mode_q};
                `MMPC_OFF_INT_STAT: rdata_q <= {{(32-3*CH_N){1'b0}}, int_stat_q};
                `MMPC_OFF_INT_MASK: rdata_q <= {{(32-3*CH_N){1'b0}}, int_mask_q};
                default:            rdata_q <= '0;
            endcase
        end
    end

    assign rdata = rdata_q;

endmodule

// *** src/mmpc_defines.svh ***
// Register map, field positions and reset values of the pulse counter.
// How it works
// - Mode selects bidirection, up/down or frequency.
// - One mode register drives all four channels.
// - Up/down mode: up pulse increments.
// - Up/down mode: down pulse decrements.
// - Simultaneous up and down pulses: no change.
// - Bidirection: second input is direction level.
// - Direction level one counts up.
// - Direction level zero counts down.
// - TTL level, open direction counts up.
// - Isolated level, open direction counts down.
// - Frequency mode counts up pulses only.
// - Per-channel high and low limits compared.
// - Signed tally tracks overflows and underflows.
// - Out of range reloads the initial value.
// - Counter spans full 32-bit unsigned range.
// - Latched high alarm holds until self-clearing clear.
`ifndef MMPC_DEFINES_SVH
`define MMPC_DEFINES_SVH
`define MMPC_ADDR_W       8
`define MMPC_OFF_CTRL     8'h00
`define MMPC_OFF_INT_STAT 8'h04
`define MMPC_OFF_INT_MASK 8'h08
`define MMPC_CH_REGION    7
`define MMPC_CH_MSB       6
`define MMPC_CH_LSB       5
`define MMPC_FLD_MSB      4
`define MMPC_FLD_LSB      2
`define MMPC_FLD_COUNT    3'h0
`define MMPC_FLD_INIT     3'h1
`define MMPC_FLD_HIGH     3'h2
`define MMPC_FLD_LOW      3'h3
`define MMPC_FLD_TALLY    3'h4
`define MMPC_FLD_ALARM    3'h5
`define MMPC_CTRL_MODE_LSB 0
`define MMPC_CTRL_MODE_MSB 1
`define MMPC_CTRL_ISO     2
`define MMPC_CTRL_LATCH   3
`define MMPC_CTRL_CLR     4
`define MMPC_CNT_MAX      32'hffffffff
`define MMPC_CNT_MIN      32'h00000000
`define MMPC_HIGH_RST     32'hffffffff
`define MMPC_LOW_RST      32'h00000000
`endif

// *** src/mmpc_pkg.sv ***
// Types shared by the pulse counter.
package mmpc_pkg;
    typedef enum logic [1:0]
    {
        MODE_UPDOWN = 2'b00,
        MODE_BIDIR  = 2'b01,
        MODE_FREQ   = 2'b10
    } mode_type;
endpackage

// *** test/mmpc_top_asserts.sv ***
// Port checker of the pulse counter, with its bind to the top module.
`include "mmpc_defines.svh"
module mmpc_chk #(
    parameter int CH_N  = 4,
    parameter int CNT_W = 32
) (
    input wire logic                    ref_clk,
    input wire logic                    nrst,
    input wire logic [`MMPC_ADDR_W-1:0] addr,
    input wire logic [31:0]             wdata,
    input wire logic                    wr,
    input wire logic                    rd,
    input wire logic [31:0]             rdata,
    input wire logic [CH_N-1:0]         up_pulse_pos,
    input wire logic [CH_N-1:0]         direction_in_pos,
    input wire logic [CH_N-1:0]         direction_open,
    input wire logic [CH_N-1:0]         high_alarm,
    input wire logic [CH_N-1:0]         low_alarm,
    input wire logic                    irq
);
    // ------------------------------------------------------------
    // Shadow of the control fields the properties depend on
    // ------------------------------------------------------------
    logic [1:0] mode_q;
    logic       latch_q;
    logic       mask_z_q;
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            mode_q   <= 2'h0;
            latch_q  <= 1'b0;
            mask_z_q <= 1'b1;
        end
        else if (wr && addr == `MMPC_OFF_CTRL)
        begin
            mode_q  <= wdata[1:0];
            latch_q <= wdata[3];
        end
        else if (wr && addr == `MMPC_OFF_INT_MASK)
        begin
            mask_z_q <= (wdata[11:0] == 12'h0);
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);
    // Counts land three edges after a pin edge, so quiet windows must cover that pipeline.
    sequence s_still; ($stable(up_pulse_pos) && $stable(direction_in_pos))[*4]; endsequence
    sequence s_quiet; ($stable(up_pulse_pos) && $stable(direction_in_pos) && !wr)[*6]; endsequence
    sequence s_mode_wr; wr && addr == 8'h00 && wdata[1:0] != mode_q; endsequence
    sequence s_clr_wr; wr && addr == 8'h00 && wdata[4]; endsequence
    property p_idle; !rd |=> rdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data not idle");
    property p_unmap; rd && addr == 8'h0c |=> rdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_alarm_rd;
        rd && addr == 8'h94 |=> rdata == {30'h0, $past(low_alarm[0]), $past(high_alarm[0])};
    endproperty
    a_alarm_rd: assert property (p_alarm_rd) else $error("alarm word differs from pins");
    property p_latch; latch_q && high_alarm[0] && !wr && !$past(wr) && !$past(wr, 2) |=> high_alarm[0]; endproperty
    a_latch: assert property (p_latch) else $error("latched alarm dropped");
    property p_clr; s_clr_wr ##1 !wr ##1 (rd && addr == 8'h00) |=> !rdata[4]; endproperty
    a_clr: assert property (p_clr) else $error("clear bit stuck");
    property p_steady; s_quiet |-> $stable(high_alarm) && $stable(low_alarm); endproperty
    a_steady: assert property (p_steady) else $error("alarm moved with quiet inputs");
    property p_mode_clr; s_still ##0 s_mode_wr ##1 !wr ##1 (rd && addr == 8'h80) |=> rdata == 32'h0; endproperty
    a_mode_clr: assert property (p_mode_clr) else $error("count kept over mode change");
    property p_irq_off; mask_z_q |=> !irq; endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt with empty mask");
endmodule
bind mmpc_top mmpc_chk #(.CH_N(CH_N), .CNT_W(CNT_W)) u_chk (
    .ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .up_pulse_pos(up_pulse_pos), .direction_in_pos(direction_in_pos), .direction_open(direction_open),
    .high_alarm(high_alarm), .low_alarm(low_alarm), .irq(irq)
);

// *** test/mmpc_src.sv ***
// Field pulse source model driving the four channel inputs.
module mmpc_src (
    input  wire logic       ref_clk,
    output logic      [3:0] up_pulse_pos,
    output logic      [3:0] direction_in_pos,
    output logic      [3:0] direction_open
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] up_q   = 4'h0;
    logic [3:0] dn_q   = 4'h0;
    logic [3:0] dir_q  = 4'h0;
    logic [3:0] open_q = 4'h0;
    logic       tog_q  = 1'b0;
    // An open line has no pull, so it shows a changing level the design must ignore.
    always @(posedge ref_clk) tog_q <= ~tog_q;
    assign up_pulse_pos     = up_q;
    assign direction_in_pos = (open_q & {4{tog_q}}) | (~open_q & (dir_q | dn_q));
    assign direction_open   = open_q;
    // Levels last two clocks, twice the shortest the inputs accept, then the count settles.
    task automatic pulse(input logic [3:0] u, input logic [3:0] d);
        @(posedge ref_clk);
        up_q <= u;
        dn_q <= d;
        repeat (2) @(posedge ref_clk);
        up_q <= 4'h0;
        dn_q <= 4'h0;
        repeat (6) @(posedge ref_clk);
    endtask
    task automatic set_lvl(input logic [3:0] dir, input logic [3:0] op);
        @(posedge ref_clk);
        dir_q  <= dir;
        open_q <= op;
    endtask
endmodule

// *** test/mmpc_top_tb.sv ***
// Self-checking bench of the four-channel pulse counter.
module mmpc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0;
    logic        nrst    = 1'b0;
    logic [7:0]  addr    = 8'h00;
    logic [31:0] wdata   = 32'h0;
    logic        wr      = 1'b0;
    logic        rd      = 1'b0;
    logic [31:0] rdata;
    logic [3:0]  up_pulse_pos;
    logic [3:0]  direction_in_pos;
    logic [3:0]  direction_open;
    logic [3:0]  high_alarm;
    logic [3:0]  low_alarm;
    logic        irq;
    int          n_mismatch = 0;
    int          checked    = 0;
    always #12.5 ref_clk = ~ref_clk;
    mmpc_top DUT (
        .ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .up_pulse_pos(up_pulse_pos), .direction_in_pos(direction_in_pos), .direction_open(direction_open),
        .high_alarm(high_alarm), .low_alarm(low_alarm), .irq(irq)
    );
    mmpc_src src (
        .ref_clk(ref_clk), .up_pulse_pos(up_pulse_pos),
        .direction_in_pos(direction_in_pos), .direction_open(direction_open)
    );
    // ------------------------------------------------------------
    // Bus cycles, comparison and verdict
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd <= 1'b0;
        @(negedge ref_clk);
        chk(rdata, exp);
    endtask
    task automatic wait_irq(input logic v);
        // Start off the edge so the level is never read where it is launched.
        @(negedge ref_clk);
        for (int k = 0; k < 8 && irq !== v; k++)
            @(negedge ref_clk);
        chk({31'h0, irq}, {31'h0, v});
    endtask
    task automatic stop_test;
        $display("mismatches=%0d checks=%0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic t_reset;
        rd_chk(8'h00, 32'h0);
        rd_chk(8'h0c, 32'h0);
        for (int c = 0; c < 4; c++)
        begin
            rd_chk(8'h80 + 8'(c * 32), 32'h0);
            rd_chk(8'h88 + 8'(c * 32), 32'hffffffff);
        end
    endtask
    task automatic t_updown;
        src.pulse(4'hf, 4'h0);
        src.pulse(4'h4, 4'h6);
        repeat (20) @(posedge ref_clk);
        for (int c = 0; c < 4; c++)
            rd_chk(8'h80 + 8'(c * 32), (c == 1) ? 32'h0 : 32'h1);
    endtask
    task automatic t_wrap;
        wr_reg(8'h84, 32'h5);
        wr_reg(8'h80, 32'hffffffff);
        src.pulse(4'h1, 4'h0);
        rd_chk(8'h80, 32'h5);
        rd_chk(8'h90, 32'h1);
        wr_reg(8'h80, 32'h0);
        src.pulse(4'h0, 4'h1);
        rd_chk(8'h80, 32'h5);
        rd_chk(8'h90, 32'h0);
        rd_chk(8'h04, 32'h100);
        wr_reg(8'h08, 32'h100);
        wait_irq(1'b1);
        wr_reg(8'h04, 32'h100);
        wait_irq(1'b0);
        rd_chk(8'h04, 32'h0);
    endtask
    task automatic t_alarm;
        wr_reg(8'h80, 32'h0);
        wr_reg(8'h88, 32'h1);
        wr_reg(8'h8c, 32'h1);
        repeat (3) @(negedge ref_clk);
        chk({30'h0, low_alarm[0], high_alarm[0]}, 32'h2);
        src.pulse(4'h1, 4'h0);
        src.pulse(4'h1, 4'h0);
        rd_chk(8'h94, 32'h1);
        wr_reg(8'h00, 32'h8);
        wr_reg(8'h88, 32'hffffffff);
        rd_chk(8'h94, 32'h1);
        wr_reg(8'h00, 32'h18);
        rd_chk(8'h00, 32'h8);
        rd_chk(8'h94, 32'h0);
    endtask
    task automatic t_bidir;
        wr_reg(8'h00, 32'h1);
        rd_chk(8'h80, 32'h0);
        src.set_lvl(4'h1, 4'h0);
        wr_reg(8'ha0, 32'ha);
        src.pulse(4'h3, 4'h0);
        rd_chk(8'h80, 32'h1);
        rd_chk(8'ha0, 32'h9);
        src.set_lvl(4'h0, 4'h1);
        src.pulse(4'h1, 4'h0);
        rd_chk(8'h80, 32'h2);
        wr_reg(8'h00, 32'h5);
        src.pulse(4'h1, 4'h0);
        rd_chk(8'h80, 32'h1);
        src.set_lvl(4'h0, 4'h0);
        wr_reg(8'h00, 32'h2);
        src.pulse(4'h1, 4'h1);
        src.pulse(4'h0, 4'h1);
        rd_chk(8'h80, 32'h1);
        wr_reg(8'h00, 32'h3);
        wr_reg(8'h80, 32'h7);
        src.pulse(4'h1, 4'h1);
        rd_chk(8'h80, 32'h7);
    endtask
    initial
    begin
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        t_reset();
        t_updown();
        t_wrap();
        t_alarm();
        t_bidir();
        stop_test();
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        stop_test();
    end
endmodule
